// file: hdl/lcr_link_capabilities.v
// Link capabilities register: nonvolatile load, port capture and config access port.
`timescale 1ns/100ps
`include "lcr_link_capabilities_map.vh"


module lcr_link_capabilities #(
  parameter ADDR_W = 12,
  parameter NVM_AW = 8
) (
  input wire clk,
  input wire rst,
  input wire cfg_rd_req,
  input wire cfg_wr_req,
  input wire [ADDR_W-1:0] cfg_addr,
  input wire [31:0] cfg_wr_data,
  input wire [3:0] cfg_byte_en,
  output wire cfg_rd_ack,
  output wire cfg_wr_ack,
  output wire cfg_hit,
  output wire [31:0] cfg_rd_data,
  output wire nvm_req,
  output wire [NVM_AW-1:0] nvm_addr,
  input wire nvm_ack,
  input wire [15:0] nvm_data,
  output wire nvm_loaded,
  input wire common_clk_cfg,
  input wire link_training,
  input wire port_num_valid,
  input wire [7:0] port_num_in
);

  // ------------------------------------------------------------------
  // Loader states.
  // ------------------------------------------------------------------
  localparam [1:0] ST_LAT = 2'h0;
  localparam [1:0] ST_ASPM = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] l0s_com_r;
  reg [2:0] l0s_com_nxt;
  reg [2:0] l0s_sep_r;
  reg [2:0] l0s_sep_nxt;
  reg [2:0] l1_lat_r;
  reg [2:0] l1_lat_nxt;
  reg [1:0] aspm_r;
  reg [1:0] aspm_nxt;

  reg rd_pend_r;
  reg rd_pend_nxt;
  reg rd_pend_hit_r;
  reg rd_pend_hit_nxt;
  reg rd_ack_r;
  reg rd_ack_nxt;
  reg wr_ack_r;
  reg wr_ack_nxt;
  reg hit_r;
  reg hit_nxt;
  reg [31:0] rd_data_r;
  reg [31:0] rd_data_nxt;

  wire [7:0] port_num;
  wire loaded;
  wire addr_hit;
  wire rd_go;
  wire [2:0] l0s_shown;
  wire [31:0] reg_value;

  assign loaded = (state_r == ST_DONE);
  assign addr_hit = (cfg_addr == `LCR_LINK_CAPABILITIES_OFFSET);

  // ------------------------------------------------------------------
  // Nonvolatile load sequence.
  // ------------------------------------------------------------------
  // Both words are fetched once after reset; the latency word comes first.
  always @* begin
    state_nxt = state_r;
    l0s_com_nxt = l0s_com_r;
    l0s_sep_nxt = l0s_sep_r;
    l1_lat_nxt = l1_lat_r;
    aspm_nxt = aspm_r;
    case (state_r)
      ST_LAT: begin
        if (nvm_ack) begin
          l0s_com_nxt = nvm_data[`LCR_NVM_L0S_COM_MSB:`LCR_NVM_L0S_COM_LSB];
          l0s_sep_nxt = nvm_data[`LCR_NVM_L0S_SEP_MSB:`LCR_NVM_L0S_SEP_LSB];
          l1_lat_nxt = nvm_data[`LCR_NVM_L1_MSB:`LCR_NVM_L1_LSB];
          state_nxt = ST_ASPM;
        end
      end
      ST_ASPM: begin
        if (nvm_ack) begin
          aspm_nxt = nvm_data[`LCR_NVM_ASPM_MSB:`LCR_NVM_ASPM_LSB];
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_DONE;
      end
      default: begin
        state_nxt = ST_LAT;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_LAT;
      l0s_com_r <= `LCR_L0S_DEFAULT;
      l0s_sep_r <= `LCR_L0S_DEFAULT;
      l1_lat_r <= `LCR_L1_DEFAULT;
      aspm_r <= `LCR_ASPM_DEFAULT;
    end else begin
      state_r <= state_nxt;
      l0s_com_r <= l0s_com_nxt;
      l0s_sep_r <= l0s_sep_nxt;
      l1_lat_r <= l1_lat_nxt;
      aspm_r <= aspm_nxt;
    end
  end

  assign nvm_req = (state_r == ST_LAT) || (state_r == ST_ASPM);
  assign nvm_addr = (state_r == ST_ASPM) ? `LCR_NVM_ASPM_WORD : `LCR_NVM_LAT_WORD;
  assign nvm_loaded = loaded;

  // ------------------------------------------------------------------
  // Port number.
  // ------------------------------------------------------------------
  lcr_port_capture #(
    .PORT_W(8)
  ) u_port (
    .clk(clk),
    .rst(rst),
    .link_training(link_training),
    .port_num_valid(port_num_valid),
    .port_num_in(port_num_in),
    .port_num(port_num)
  );

  // ------------------------------------------------------------------
  // Register image.
  // ------------------------------------------------------------------
  // The clock mode is read live, so software changing it is seen on the next read.
  assign l0s_shown = common_clk_cfg ? l0s_com_r : l0s_sep_r;

  assign reg_value[`LCR_SPEED_MSB:`LCR_SPEED_LSB] = `LCR_SPEED_2G5;
  assign reg_value[`LCR_WIDTH_MSB:`LCR_WIDTH_LSB] = `LCR_WIDTH_X1;
  assign reg_value[`LCR_ASPM_MSB:`LCR_ASPM_LSB] = aspm_r;
  assign reg_value[`LCR_L0S_MSB:`LCR_L0S_LSB] = l0s_shown;
  assign reg_value[`LCR_L1_MSB:`LCR_L1_LSB] = l1_lat_r;
  assign reg_value[`LCR_RSVD18_BIT] = 1'h0;
  assign reg_value[`LCR_SDERR_BIT] = `LCR_SDERR_VALUE;
  assign reg_value[`LCR_DLLACT_BIT] = `LCR_DLLACT_VALUE;
  assign reg_value[`LCR_RSVD_HI_MSB:`LCR_RSVD_HI_LSB] = 3'h0;
  assign reg_value[`LCR_PORT_MSB:`LCR_PORT_LSB] = port_num;

  // ------------------------------------------------------------------
  // Configuration access port.
  // ------------------------------------------------------------------
  // The first read that arrives before the load ends is parked, not answered with
  // defaults; its requester just sees a longer completion time, and reads arriving while it waits are dropped.
  assign rd_go = loaded && (cfg_rd_req || rd_pend_r);

  always @* begin
    rd_pend_nxt = rd_pend_r;
    rd_pend_hit_nxt = rd_pend_hit_r;
    rd_ack_nxt = 1'h0;
    wr_ack_nxt = 1'h0;
    hit_nxt = hit_r;
    rd_data_nxt = rd_data_r;
    if (cfg_rd_req && !rd_pend_r && !loaded) begin
      rd_pend_nxt = 1'h1;
      rd_pend_hit_nxt = addr_hit;
    end
    if (rd_go) begin
      rd_pend_nxt = 1'h0;
      rd_ack_nxt = 1'h1;
      hit_nxt = rd_pend_r ? rd_pend_hit_r : addr_hit;
      rd_data_nxt = (rd_pend_r ? rd_pend_hit_r : addr_hit) ? reg_value : 32'h0000_0000;
    end else if (cfg_wr_req) begin
      // Write data and byte enables are accepted and dropped.
      wr_ack_nxt = 1'h1;
      hit_nxt = addr_hit;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rd_pend_r <= 1'h0;
      rd_pend_hit_r <= 1'h0;
      rd_ack_r <= 1'h0;
      wr_ack_r <= 1'h0;
      hit_r <= 1'h0;
      rd_data_r <= 32'h0000_0000;
    end else begin
      rd_pend_r <= rd_pend_nxt;
      rd_pend_hit_r <= rd_pend_hit_nxt;
      rd_ack_r <= rd_ack_nxt;
      wr_ack_r <= wr_ack_nxt;
      hit_r <= hit_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign cfg_rd_ack = rd_ack_r;
  assign cfg_wr_ack = wr_ack_r;
  assign cfg_hit = hit_r;
  assign cfg_rd_data = rd_data_r;

endmodule

// file: hdl/lcr_link_capabilities_map.vh
// Constants for the link capabilities register: offsets, field layout, defaults and loads.
`ifndef LCR_LINK_CAPABILITIES_MAP_VH
`define LCR_LINK_CAPABILITIES_MAP_VH

// ------------------------------------------------------------------
// Register offset in configuration space.
// ------------------------------------------------------------------
`define LCR_LINK_CAPABILITIES_OFFSET 12'h0ec

// ------------------------------------------------------------------
// Field positions inside the 32-bit register.
// ------------------------------------------------------------------
`define LCR_SPEED_LSB 0
`define LCR_SPEED_MSB 3
`define LCR_WIDTH_LSB 4
`define LCR_WIDTH_MSB 9
`define LCR_ASPM_LSB 10
`define LCR_ASPM_MSB 11
`define LCR_L0S_LSB 12
`define LCR_L0S_MSB 14
`define LCR_L1_LSB 15
`define LCR_L1_MSB 17
`define LCR_RSVD18_BIT 18
`define LCR_SDERR_BIT 19
`define LCR_DLLACT_BIT 20
`define LCR_RSVD_HI_LSB 21
`define LCR_RSVD_HI_MSB 23
`define LCR_PORT_LSB 24
`define LCR_PORT_MSB 31

// ------------------------------------------------------------------
// Fixed values and reset defaults.
// ------------------------------------------------------------------
`define LCR_SPEED_2G5 4'h1
`define LCR_WIDTH_X1 6'h01
`define LCR_ASPM_DEFAULT 2'h3
`define LCR_L0S_DEFAULT 3'h1
`define LCR_L1_DEFAULT 3'h6
`define LCR_SDERR_VALUE 1'h0
`define LCR_DLLACT_VALUE 1'h0
`define LCR_PORT_DEFAULT 8'h00

// ------------------------------------------------------------------
// Nonvolatile word addresses and field positions within the words.
// ------------------------------------------------------------------
`define LCR_NVM_LAT_WORD 8'h18
`define LCR_NVM_ASPM_WORD 8'h1a
`define LCR_NVM_L0S_COM_LSB 0
`define LCR_NVM_L0S_COM_MSB 2
`define LCR_NVM_L0S_SEP_LSB 3
`define LCR_NVM_L0S_SEP_MSB 5
`define LCR_NVM_L1_LSB 6
`define LCR_NVM_L1_MSB 8
`define LCR_NVM_ASPM_LSB 2
`define LCR_NVM_ASPM_MSB 3

`endif

// file: hdl/lcr_port_capture.v
// Port number holding register loaded while link training runs.
`timescale 1ns/100ps
`include "lcr_link_capabilities_map.vh"

module lcr_port_capture #(
  parameter PORT_W = 8
) (
  input wire clk,
  input wire rst,
  input wire link_training,
  input wire port_num_valid,
  input wire [PORT_W-1:0] port_num_in,
  output wire [PORT_W-1:0] port_num
);

  reg [PORT_W-1:0] port_num_r;
  reg [PORT_W-1:0] port_num_nxt;

  // ------------------------------------------------------------------
  // Capture.
  // ------------------------------------------------------------------
  // Outside training the number is frozen, so a stray strobe cannot move it.
  always @* begin
    port_num_nxt = port_num_r;
    if (link_training && port_num_valid) begin
      port_num_nxt = port_num_in;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      port_num_r <= `LCR_PORT_DEFAULT;
    end else begin
      port_num_r <= port_num_nxt;
    end
  end

  assign port_num = port_num_r;

endmodule

// file: dv/lcr_link_capabilities_monitor.sv
// Port checker for the link capabilities register.
`timescale 1ns/100ps
module lcr_link_capabilities_monitor (
  input wire clk,
  input wire rst,
  input wire cfg_rd_req,
  input wire cfg_wr_req,
  input wire cfg_rd_ack,
  input wire cfg_wr_ack,
  input wire cfg_hit,
  input wire [31:0] cfg_rd_data,
  input wire nvm_req,
  input wire [7:0] nvm_addr,
  input wire nvm_ack,
  input wire nvm_loaded
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rd_ack_next: assert property (
    (cfg_rd_req && nvm_loaded && $past(nvm_loaded)) |=> cfg_rd_ack) else $error("read lost");
  a_fixed_link_fields: assert property (
    (cfg_rd_ack && cfg_hit) |-> cfg_rd_data[9:0] == 10'h011) else $error("bad speed or width");
  a_zero_mid_bits: assert property (
    cfg_rd_ack |-> cfg_rd_data[23:18] == 6'h00) else $error("bits 23:18 not zero");
  a_miss_reads_zero: assert property (
    (cfg_rd_ack && !cfg_hit) |-> cfg_rd_data == 32'h0) else $error("miss data not zero");
  a_wr_acked: assert property (
    (cfg_wr_req && !cfg_rd_req && nvm_loaded && $past(nvm_loaded)) |=> cfg_wr_ack)
    else $error("write not answered");
  a_wr_keeps_data: assert property (
    cfg_wr_ack |-> $stable(cfg_rd_data)) else $error("write changed data");
  a_nvm_second_word: assert property (
    (nvm_req && nvm_ack && nvm_addr == 8'h18) |=> (nvm_req && nvm_addr == 8'h1a))
    else $error("second word not fetched");
  a_nvm_load_done: assert property (
    (nvm_req && nvm_ack && nvm_addr == 8'h1a) |=> (!nvm_req && nvm_loaded))
    else $error("load not finished");
  a_no_early_read: assert property (
    !nvm_loaded |-> !cfg_rd_ack) else $error("read answered before load");
  c_parked_read: cover property (cfg_rd_req && !nvm_loaded);
  c_write_ack: cover property (cfg_wr_ack && cfg_hit);
  c_miss_read: cover property (cfg_rd_ack && !cfg_hit);
endmodule

bind lcr_link_capabilities lcr_link_capabilities_monitor mon_u (.clk(clk), .rst(rst), .cfg_rd_req(cfg_rd_req),
  .cfg_wr_req(cfg_wr_req), .cfg_rd_ack(cfg_rd_ack), .cfg_wr_ack(cfg_wr_ack),
  .cfg_hit(cfg_hit), .cfg_rd_data(cfg_rd_data), .nvm_req(nvm_req), .nvm_addr(nvm_addr),
  .nvm_ack(nvm_ack), .nvm_loaded(nvm_loaded));

// file: dv/lcr_nvm_model.sv
// Nonvolatile word store answering the load requests after a set delay.
`timescale 1ns/100ps
module lcr_nvm_model (
  input wire clk,
  input wire rst,
  input wire nvm_req,
  input wire [7:0] nvm_addr,
  input wire [3:0] dly,
  input wire [15:0] w18,
  input wire [15:0] w1a,
  output wire nvm_ack,
  output wire [15:0] nvm_data
);
  reg [3:0] cnt_r;
  reg ack_r;
  wire [15:0] word = (nvm_addr == 8'h1a) ? w1a : w18;
  // Outside the ack cycle the data is inverted so a late sample shows up as wrong.
  assign nvm_data = ack_r ? word : ~word;
  assign nvm_ack = ack_r;
  always @(posedge clk) begin
    if (rst || !nvm_req || ack_r) begin
      cnt_r <= 4'h0;
      ack_r <= 1'b0;
    end else if (cnt_r == dly) begin
      ack_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

// file: dv/lcr_link_capabilities_tb.sv
// Self-checking bench for the link capabilities register.
`timescale 1ns/100ps
module lcr_link_capabilities_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg cc = 1'b0;
  reg trn = 1'b0;
  reg pv = 1'b0;
  reg [7:0] pin = 8'h00;
  reg [11:0] addr = 12'h000;
  reg [31:0] wd = 32'h0;
  reg [3:0] be = 4'h0;
  reg [15:0] w18 = 16'h0;
  reg [15:0] w1a = 16'h0;
  reg [7:0] port = 8'h00;
  reg [3:0] dly = 4'h0;
  reg [32:0] q[$];
  reg wq[$];
  integer seed = 18;
  integer error_cnt = 0;
  integer n_checks = 0;
  integer r;
  integer i;
  wire rack, wack, hit, nreq, nack, nld;
  wire [31:0] rdat;
  wire [7:0] naddr;
  wire [15:0] ndat;
  lcr_link_capabilities dut_u (.clk(clk), .rst(rst), .cfg_rd_req(rd), .cfg_wr_req(wr), .cfg_addr(addr),
    .cfg_wr_data(wd), .cfg_byte_en(be), .cfg_rd_ack(rack), .cfg_wr_ack(wack), .cfg_hit(hit),
    .cfg_rd_data(rdat), .nvm_req(nreq), .nvm_addr(naddr), .nvm_ack(nack), .nvm_data(ndat),
    .nvm_loaded(nld), .common_clk_cfg(cc), .link_training(trn), .port_num_valid(pv),
    .port_num_in(pin));
  lcr_nvm_model nvm_u (.clk(clk), .rst(rst), .nvm_req(nreq), .nvm_addr(naddr), .dly(dly),
    .w18(w18), .w1a(w1a), .nvm_ack(nack), .nvm_data(ndat));
  initial begin
    forever #25 clk = ~clk;
  end
  function [31:0] expv(input c);
    expv = {port, 6'h00, w18[8:6], c ? w18[2:0] : w18[5:3], w1a[3:2], 6'h01, 4'h1};
  endfunction
  task check(input [32:0] seen, input [32:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      if (error_cnt == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task acc(input w, input [11:0] a);
    begin
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wd <= $random(seed);
      be <= $random(seed);
      if (!w) q.push_back({a == 12'h0ec, (a == 12'h0ec) ? expv(cc) : 32'h0});
      if (w) wq.push_back(a == 12'h0ec);
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task cap(input t);
    reg [7:0] v;
    begin
      v = $random(seed);
      @(posedge clk);
      trn <= t;
      pv <= 1'b1;
      pin <= v;
      if (t) port = v;
      @(posedge clk);
      pv <= 1'b0;
      trn <= 1'b0;
    end
  endtask
  // Each read answer is matched against the oldest expectation.
  always @(posedge clk) begin
    if (rack === 1'b1) begin
      check({32'h0, q.size() != 0}, 33'h1);
      if (q.size() != 0) check({hit, rdat}, q.pop_front());
    end
    // A write is answered with an acknowledge whose hit flag tells whether it decoded.
    if (wack === 1'b1) begin
      check({32'h0, wq.size() != 0}, 33'h1);
      if (wq.size() != 0) check({32'h0, hit}, {32'h0, wq.pop_front()});
    end
  end
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    finish_test;
  end
  initial begin
    for (r = 0; r < 4; r = r + 1) begin
      w18 = $random(seed);
      w1a = $random(seed);
      w1a[3:2] = r[1:0];
      dly = r;
      port = 8'h00;
      @(posedge clk);
      rst <= 1'b1;
      cc <= r[0];
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      acc(1'b0, 12'h0ec);
      i = 0;
      while (nld !== 1'b1 && i < 100) begin
        @(posedge clk);
        i = i + 1;
      end
      check({32'h0, nld}, 33'h1);
      acc(1'b0, 12'h0e8);
      acc(1'b1, 12'h0ec);
      acc(1'b0, 12'h0ec);
      cap(1'b0);
      acc(1'b0, 12'h0ec);
      cap(1'b1);
      acc(1'b0, 12'h0ec);
      @(posedge clk);
      cc <= !cc;
      acc(1'b0, 12'h0ec);
    end
    repeat (4) @(posedge clk);
    check({32'h0, q.size() == 0}, 33'h1);
    check({32'h0, wq.size() == 0}, 33'h1);
    finish_test;
  end
endmodule
